// File: design/aiolim_top.sv
// top: register file, channels and interrupt for the analogue limit block
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - With the user lower check on, a channel value below the user low value flags an error.
// - The scale low limit spans -32767..32766, resets to 0, and with its check on in scaled format flags values below it.
// - On a comm fault a channel with fault output on drives its fault value while priority selects software control, else holds.
// - On controller idle without a comm fault, a channel with idle output on drives its idle value, else holds.
// - Per-channel fault selection counts only while priority selects software control.
// - Scaled format decodes set, fault and idle values from sign-magnitude to two's complement.
// - Scale high accepts -32766..32767 and scale low -32767..32766 in any range.
// - Scaled set values 0..32767 mean +0..+32767 and 32768..65535 mean -0..-32767.
module aiolim_top
  import aiolim_pkg::*;
#(
  parameter int NCH = 4
)(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // analogue outputs
  output logic [16*NCH-1:0] ch_out,
  // interrupt
  output logic             irq
);

  if (NCH < 1 || NCH > 6) begin : g_bad_nch
    $error("NCH must be 1 to 6");
  end

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic        awhave;
    logic        whave;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        comm_fault;
    logic        idle;
    logic [1:0]  prio;
    logic [7:0]  status;
    logic [7:0]  mask;
  } aiolim_top_st_t;

  aiolim_top_st_t s_q;
  aiolim_top_st_t s_d;

  logic [4:0]  cfg_q   [NCH];
  logic [15:0] ulow_q  [NCH];
  logic [15:0] slow_q  [NCH];
  logic [15:0] sup_q   [NCH];
  logic [15:0] faultv_q[NCH];
  logic [15:0] idlev_q [NCH];
  logic [15:0] setv_q  [NCH];
  logic [NCH-1:0] diag;
  logic [15:0] outv [NCH];

  logic        wr_go;
  logic        rd_go;
  logic [7:0]  rd_addr;

  assign wr_go = s_q.awhave && s_q.whave && !s_q.bvalid;
  assign rd_go = s_axi_arvalid && !s_q.rvalid;
  assign rd_addr = s_axi_araddr;

  // ***************************************************************
  // channels
  // ***************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      aiolim_cfg_if cif ();
      logic        wsel;
      logic [2:0]  widx;
      logic [15:0] wv;
      assign wsel = wr_go && (s_q.awaddr >= REG_CH_BASE)
                    && (((s_q.awaddr - REG_CH_BASE) >> 5) == 8'(gi));
      assign widx = s_q.awaddr[4:2];
      assign wv   = s_q.wdata[15:0];
      assign cif.ulow_en    = cfg_q[gi][CFG_ULOW_EN];
      assign cif.slow_en    = cfg_q[gi][CFG_SLOW_EN];
      assign cif.fault_en   = cfg_q[gi][CFG_FAULT_EN];
      assign cif.idle_en    = cfg_q[gi][CFG_IDLE_EN];
      assign cif.scaled     = cfg_q[gi][CFG_SCALED];
      assign cif.ulow       = ulow_q[gi];
      assign cif.slow       = slow_q[gi];
      assign cif.sup        = sup_q[gi];
      assign cif.faultv     = faultv_q[gi];
      assign cif.idlev      = idlev_q[gi];
      assign cif.setv       = setv_q[gi];
      assign cif.comm_fault = s_q.comm_fault;
      assign cif.idle       = s_q.idle;
      assign cif.sw_prio    = (s_q.prio == PRIO_SOFTWARE);
      assign diag[gi]       = cif.ulow_err || cif.slow_err;
      assign outv[gi]       = cif.out_val;
      assign ch_out[16*gi +: 16] = cif.out_val;

      aiolim_limit_chk u_chk (
        .core_clk (core_clk),
        .resetn   (resetn),
        .ch       (cif.chk)
      );
      aiolim_out_sel u_sel (
        .core_clk (core_clk),
        .resetn   (resetn),
        .ch       (cif.sel)
      );

      always_ff @(posedge core_clk) begin
        if (!resetn) begin
          cfg_q[gi]    <= '0;
          ulow_q[gi]   <= ULOW_RESET;
          slow_q[gi]   <= SLOW_RESET;
          sup_q[gi]    <= SUP_RESET;
          faultv_q[gi] <= '0;
          idlev_q[gi]  <= '0;
          setv_q[gi]   <= '0;
        end else if (wsel) begin
          case (widx)
            CH_CFG:    cfg_q[gi] <= s_q.wdata[4:0];
            CH_ULOW:   ulow_q[gi] <= wv;
            CH_SLOW:   if ($signed(wv) >= $signed(SCALE_MIN) && $signed(wv) <= $signed(SLOW_MAX))
                         slow_q[gi] <= wv;
            CH_SUP:    if ($signed(wv) >= $signed(SUP_MIN))
                         sup_q[gi] <= wv;
            CH_FAULTV: faultv_q[gi] <= wv;
            CH_IDLEV:  idlev_q[gi] <= wv;
            CH_SETV:   setv_q[gi] <= wv;
            default:   ;
          endcase
        end
      end
    end
  endgenerate

  // ***************************************************************
  // read mux
  // ***************************************************************
  function automatic logic [31:0] rd_word(input logic [7:0] a, input aiolim_top_st_t st,
                                          input logic [NCH-1:0] dg);
    logic [31:0] r;
    logic [7:0]  rel;
    int          c;
    r = 32'h0000_0000;
    rel = a - REG_CH_BASE;
    c = int'(rel >> 5);
    if (a == REG_CTRL) begin
      r = {26'h0, st.prio, 2'h0, st.idle, st.comm_fault};
    end else if (a == REG_STATUS) begin
      r = {24'h0, st.status};
    end else if (a == REG_MASK) begin
      r = {24'h0, st.mask};
    end else if (a == REG_DIAG) begin
      r = 32'(dg);
    end else if (a >= REG_CH_BASE && c < NCH) begin
      case (rel[4:2])
        CH_CFG:    r = {27'h0, cfg_q[c]};
        CH_ULOW:   r = {16'h0, ulow_q[c]};
        CH_SLOW:   r = {16'h0, slow_q[c]};
        CH_SUP:    r = {16'h0, sup_q[c]};
        CH_FAULTV: r = {16'h0, faultv_q[c]};
        CH_IDLEV:  r = {16'h0, idlev_q[c]};
        CH_SETV:   r = {16'h0, setv_q[c]};
        default:   r = {16'h0, outv[c]};
      endcase
    end
    return r;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - REG_CH_BASE;
    return (a[1:0] == 2'h0) && ((a <= REG_DIAG)
           || (a >= REG_CH_BASE && int'(rel >> 5) < NCH));
  endfunction

  // ***************************************************************
  // bus and control
  // ***************************************************************
  always_comb begin
    s_d = s_q;
    if (s_axi_awvalid && !s_q.awhave) begin
      s_d.awhave = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.whave) begin
      s_d.whave = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (wr_go) begin
      s_d.awhave = 1'b0;
      s_d.whave  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = addr_ok(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_q.awaddr == REG_CTRL && s_q.wstrb[0]) begin
        s_d.comm_fault = s_q.wdata[CTRL_COMM_FAULT];
        s_d.idle       = s_q.wdata[CTRL_IDLE];
        s_d.prio       = s_q.wdata[CTRL_PRIO_LO +: 2];
      end
      if (s_q.awaddr == REG_STATUS && s_q.wstrb[0]) begin
        s_d.status = s_q.status & ~s_q.wdata[7:0];
      end
      if (s_q.awaddr == REG_MASK && s_q.wstrb[0]) begin
        s_d.mask = s_q.wdata[7:0];
      end
    end
    s_d.status[NCH-1:0] = s_d.status[NCH-1:0] | diag;
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (rd_go) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd_word(rd_addr, s_q, diag);
      s_d.rresp  = addr_ok(rd_addr) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = !s_q.awhave;
  assign s_axi_wready  = !s_q.whave;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign irq           = |(s_q.status & s_q.mask);

  AST_STATUS_STICKY: assert property (@(posedge core_clk) disable iff (!resetn)
    diag[0] |=> s_q.status[0]) else $error("diag event not latched");
  AST_IRQ: assert property (@(posedge core_clk) disable iff (!resetn)
    ((|(diag & s_q.mask[NCH-1:0])) && !wr_go) |=> irq) else $error("irq not raised");
  AST_BRESP: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_go |=> s_axi_bvalid) else $error("no write response");
  AST_RRESP: assert property (@(posedge core_clk) disable iff (!resetn)
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");

endmodule
`default_nettype wire

// File: shared/aiolim_pkg.sv
// package: register map, field layout and encodings for the analogue limit block
package aiolim_pkg;

  // ***************************************************************
  // register byte offsets
  // ***************************************************************
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_MASK     = 8'h08;
  localparam logic [7:0] REG_DIAG     = 8'h0C;
  localparam logic [7:0] REG_CH_BASE  = 8'h40;
  localparam logic [7:0] REG_CH_STEP  = 8'h20;
  // per channel word offsets within a channel slot
  localparam logic [2:0] CH_CFG       = 3'h0;
  localparam logic [2:0] CH_ULOW      = 3'h1;
  localparam logic [2:0] CH_SLOW      = 3'h2;
  localparam logic [2:0] CH_SUP       = 3'h3;
  localparam logic [2:0] CH_FAULTV    = 3'h4;
  localparam logic [2:0] CH_IDLEV     = 3'h5;
  localparam logic [2:0] CH_SETV      = 3'h6;
  localparam logic [2:0] CH_OUT       = 3'h7;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int CTRL_COMM_FAULT = 0;
  localparam int CTRL_IDLE       = 1;
  localparam int CTRL_PRIO_LO    = 4;
  localparam int CFG_ULOW_EN     = 0;
  localparam int CFG_SLOW_EN     = 1;
  localparam int CFG_FAULT_EN    = 2;
  localparam int CFG_IDLE_EN     = 3;
  localparam int CFG_SCALED      = 4;

  // ***************************************************************
  // values and encodings
  // ***************************************************************
  localparam logic [1:0]  PRIO_SOFTWARE = 2'h0;
  localparam logic [15:0] SLOW_RESET    = 16'h0000;
  localparam logic [15:0] SUP_RESET     = 16'h03E8;
  localparam logic [15:0] ULOW_RESET    = 16'h0000;
  localparam logic [15:0] SCALE_MIN     = 16'h8001;
  localparam logic [15:0] SCALE_MAX     = 16'h7FFF;
  localparam logic [15:0] SUP_MIN       = 16'h8002;
  localparam logic [15:0] SLOW_MAX      = 16'h7FFE;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    OSEL_LIVE,
    OSEL_HOLD,
    OSEL_FAULT,
    OSEL_IDLE
  } aiolim_osel_t;

endpackage

// File: shared/aiolim_cfg_if.sv
// interface: one channel's settings and its check results
`timescale 1ns/10ps
`default_nettype none
interface aiolim_cfg_if;
  logic        ulow_en;
  logic        slow_en;
  logic        fault_en;
  logic        idle_en;
  logic        scaled;
  logic [15:0] ulow;
  logic [15:0] slow;
  logic [15:0] sup;
  logic [15:0] faultv;
  logic [15:0] idlev;
  logic [15:0] setv;
  logic        comm_fault;
  logic        idle;
  logic        sw_prio;
  logic        ulow_err;
  logic        slow_err;
  logic [15:0] out_val;
  logic [15:0] value;
  modport top (output ulow_en, slow_en, fault_en, idle_en, scaled, ulow, slow, sup,
               faultv, idlev, setv, comm_fault, idle, sw_prio,
               input ulow_err, slow_err, out_val, value);
  modport chk (input ulow_en, slow_en, scaled, ulow, slow, value,
               output ulow_err, slow_err);
  modport sel (input fault_en, idle_en, scaled, faultv, idlev, setv, comm_fault, idle,
               sw_prio, output out_val, value);
endinterface
`default_nettype wire

// File: design/aiolim_limit_chk.sv
// lower limit checks of one channel
`timescale 1ns/10ps
`default_nettype none
module aiolim_limit_chk
  import aiolim_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // channel
  aiolim_cfg_if.chk ch
);

  typedef struct packed {
    logic ulow_err;
    logic slow_err;
  } aiolim_chk_st_t;

  aiolim_chk_st_t s_q;
  aiolim_chk_st_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.ulow_err = ch.ulow_en && ($signed(ch.value) < $signed(ch.ulow));
    s_d.slow_err = ch.slow_en && ch.scaled && ($signed(ch.value) < $signed(ch.slow));
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ch.ulow_err = s_q.ulow_err;
  assign ch.slow_err = s_q.slow_err;

  AST_ULOW_OFF: assert property (@(posedge core_clk) disable iff (!resetn)
    !$past(ch.ulow_en) |-> !ch.ulow_err) else $error("user low error while disabled");
  AST_SLOW_CHK: assert property (@(posedge core_clk) disable iff (!resetn)
    $past(ch.slow_en && ch.scaled && ($signed(ch.value) < $signed(ch.slow))) |-> ch.slow_err)
    else $error("scale low error missed");

endmodule
`default_nettype wire

// File: design/aiolim_out_sel.sv
// output value selection and sign magnitude decode of one channel
`timescale 1ns/10ps
`default_nettype none
module aiolim_out_sel
  import aiolim_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // channel
  aiolim_cfg_if.sel ch
);

  typedef struct packed {
    logic [15:0]  out_val;
    aiolim_osel_t osel;
  } aiolim_sel_st_t;

  aiolim_sel_st_t s_q;
  aiolim_sel_st_t s_d;
  logic [15:0]    live;

  function automatic logic [15:0] sm_to_tc(input logic [15:0] v);
    logic [15:0] r;
    r = v[15] ? (16'h0000 - {1'b0, v[14:0]}) : v;
    return r;
  endfunction

  assign live = ch.scaled ? sm_to_tc(ch.setv) : ch.setv;

  always_comb begin
    s_d = s_q;
    if (ch.comm_fault && ch.sw_prio) begin
      s_d.osel = ch.fault_en ? OSEL_FAULT : OSEL_HOLD;
    end else if (ch.comm_fault) begin
      s_d.osel = OSEL_HOLD;
    end else if (ch.idle) begin
      s_d.osel = ch.idle_en ? OSEL_IDLE : OSEL_HOLD;
    end else begin
      s_d.osel = OSEL_LIVE;
    end
    case (s_d.osel)
      OSEL_LIVE:  s_d.out_val = live;
      OSEL_FAULT: s_d.out_val = ch.scaled ? sm_to_tc(ch.faultv) : ch.faultv;
      OSEL_IDLE:  s_d.out_val = ch.scaled ? sm_to_tc(ch.idlev) : ch.idlev;
      default:    s_d.out_val = s_q.out_val;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_q <= '{out_val: 16'h0000, osel: OSEL_LIVE};
    end else begin
      s_q <= s_d;
    end
  end

  assign ch.out_val = s_q.out_val;
  assign ch.value   = live;

  AST_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    (ch.comm_fault && !(ch.fault_en && ch.sw_prio)) |=> $stable(ch.out_val))
    else $error("output not held on fault");
  AST_IDLEV: assert property (@(posedge core_clk) disable iff (!resetn)
    (!ch.comm_fault && ch.idle && ch.idle_en && !ch.scaled)
    |=> (ch.out_val == $past(ch.idlev))) else $error("idle value not driven");

endmodule
`default_nettype wire

// File: testbench/aiolim_plc_model.sv
// partner model: fieldbus master setting parameters over axi4-lite
`timescale 1ns/10ps
`default_nettype none
module aiolim_plc_model (
  // clock
  input  wire logic        core_clk,
  // write channels
  output var logic [7:0]   awaddr,
  output var logic         awvalid,
  input  wire logic        awready,
  output var logic [31:0]  wdata,
  output var logic [3:0]   wstrb,
  output var logic         wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output var logic         bready,
  // read channels
  output var logic [7:0]   araddr,
  output var logic         arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output var logic         rready
);
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'hF;
  end

  // set value: millivolts or microamps/10 as value divided by 10, clamped to 0..span
  function automatic logic [31:0] enc(input int milli, input int rng);
    int span;
    int v;
    span = (rng == 0) ? 1050 : (rng == 1) ? 525 : 2100;
    v = milli / 10;
    if (v > span) v = span;
    if (v < 0) v = 0;
    return v;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic sa;
    logic sw;
    logic sb;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    sb = 1'b0;
    while (!sb) begin
      @(negedge core_clk);
      sa = awvalid && awready;
      sw = wvalid && wready;
      sb = bvalid;
      r = bresp;
      @(posedge core_clk);
      if (sa) begin
        awvalid <= 1'b0;
        awaddr <= ~awaddr;
      end
      if (sw) begin
        wvalid <= 1'b0;
        wdata <= ~wdata;
      end
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic sa;
    logic sr;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    sr = 1'b0;
    while (!sr) begin
      @(negedge core_clk);
      sa = arvalid && arready;
      sr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge core_clk);
      if (sa) begin
        arvalid <= 1'b0;
        araddr <= ~araddr;
      end
    end
    rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: testbench/test_analog_io_limit_fault_scaling.sv
// testbench: analogue limit block against an integer model
`timescale 1ns/10ps
`default_nettype none
module test_analog_io_limit_fault_scaling;
  import aiolim_pkg::*;
  logic core_clk, resetn, irq;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [63:0] ch_out;
  int failures, n_compared, cyc;
  int m_set[4], m_flt[4], m_idl[4], m_cfg[4], m_out[4], m_ulow[4], m_slow[4], m_sup[4];
  int m_ctrl, m_mask, m_stat, m_diag;

  aiolim_plc_model plc (.core_clk(core_clk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  aiolim_top #(.NCH(4)) uut (.core_clk(core_clk), .resetn(resetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ch_out(ch_out), .irq(irq));

  // ***************************************************************
  // model
  // ***************************************************************
  function automatic int s16(input int v);
    logic signed [15:0] t;
    t = v[15:0];
    return t;
  endfunction

  function automatic int dec(input int c, input int v);
    if (m_cfg[c][CFG_SCALED] && v[15]) return (-(v & 32'h7FFF)) & 32'hFFFF;
    return v & 32'hFFFF;
  endfunction

  function automatic void upd();
    int v;
    m_diag = 0;
    for (int c = 0; c < 4; c++) begin
      if (m_ctrl[0]) begin
        if (m_cfg[c][2] && m_ctrl[5:4] == 0) m_out[c] = dec(c, m_flt[c]);
      end else if (m_ctrl[1]) begin
        if (m_cfg[c][3]) m_out[c] = dec(c, m_idl[c]);
      end else begin
        m_out[c] = dec(c, m_set[c]);
      end
      v = s16(dec(c, m_set[c]));
      if ((m_cfg[c][0] && v < s16(m_ulow[c])) || (m_cfg[c][4] && m_cfg[c][1] &&
          v < s16(m_slow[c]))) m_diag |= 1 << c;
    end
    m_stat |= m_diag;
  endfunction

  function automatic logic [7:0] ra(input int c, input logic [2:0] o);
    return 8'(REG_CH_BASE + REG_CH_STEP * c + 4 * o);
  endfunction

  // ***************************************************************
  // tasks
  // ***************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input int d);
    logic [1:0] r;
    int c;
    plc.wr(a, d, r);
    check(r, RESP_OKAY);
    c = (a - 8'h40) >> 5;
    if (a == REG_CTRL) m_ctrl = d;
    else if (a == REG_MASK) m_mask = d;
    else if (a == REG_STATUS) m_stat &= ~d;
    else if (a >= REG_CH_BASE) begin
      case (a[4:2])
        CH_CFG: m_cfg[c] = d;
        CH_ULOW: m_ulow[c] = d;
        CH_SLOW: if (d[15:0] != 16'h7FFF && d[15:0] != 16'h8000) m_slow[c] = d;
        CH_SUP: if (d[15:0] != 16'h8000 && d[15:0] != 16'h8001) m_sup[c] = d;
        CH_FAULTV: m_flt[c] = d;
        CH_IDLEV: m_idl[c] = d;
        CH_SETV: m_set[c] = d;
        default: ;
      endcase
    end
    upd();
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    for (int i = 0; i < 4; i++) check(ch_out[16*i +: 16], m_out[i]);
    check(irq, (m_stat & m_mask) != 0);
  endtask

  task automatic rreg(input logic [7:0] a, input int exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    plc.rd(a, d, r);
    check(r, er);
    check(d, exp);
  endtask

  task automatic finish_test();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end

  // ***************************************************************
  // scenarios
  // ***************************************************************
  initial begin
    logic [1:0] r;
    int sl[4];
    int sm[5];
    resetn = 1'b0;
    for (int c = 0; c < 4; c++) m_sup[c] = 1000;
    sl = '{32'h7FFF, 32'h8000, 32'h8001, 32'h7FFE};
    sm = '{32'h0000, 32'h7FFF, 32'h8000, 32'h8005, 32'hFFFF};
    void'($urandom(54));
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      rreg(ra(c, CH_SLOW), 0, RESP_OKAY);
      rreg(ra(c, CH_SUP), 1000, RESP_OKAY);
    end
    rreg(8'h10, 0, RESP_SLVERR);
    plc.wr(8'h14, 32'h1, r);
    check(r, RESP_SLVERR);
    wreg(REG_MASK, 1);
    for (int i = 0; i < 4; i++) wreg(ra(0, CH_SETV), plc.enc($urandom_range(0, 11000), 0));
    wreg(ra(0, CH_ULOW), 500);
    wreg(ra(0, CH_CFG), 1);
    wreg(ra(0, CH_SETV), 400);
    rreg(REG_DIAG, 1, RESP_OKAY);
    wreg(ra(0, CH_SETV), 600);
    rreg(REG_DIAG, 0, RESP_OKAY);
    rreg(REG_STATUS, 1, RESP_OKAY);
    wreg(REG_STATUS, 1);
    wreg(ra(0, CH_CFG), 0);
    wreg(ra(0, CH_SETV), 100);
    rreg(REG_STATUS, 0, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      wreg(ra(1, CH_SLOW), sl[i]);
      rreg(ra(1, CH_SLOW), m_slow[1] & 32'hFFFF, RESP_OKAY);
      wreg(ra(1, CH_SUP), sl[i] + 1);
      rreg(ra(1, CH_SUP), m_sup[1] & 32'hFFFF, RESP_OKAY);
    end
    wreg(ra(0, CH_CFG), 32'h10);
    for (int i = 0; i < 5; i++) wreg(ra(0, CH_SETV), sm[i]);
    for (int i = 0; i < 3; i++) wreg(ra(0, CH_SETV), $urandom_range(0, 65535));
    wreg(ra(0, CH_SLOW), 100);
    wreg(ra(0, CH_CFG), 32'h12);
    wreg(ra(0, CH_SETV), 50);
    rreg(REG_DIAG, 1, RESP_OKAY);
    wreg(ra(0, CH_SETV), 32'h8001);
    rreg(REG_DIAG, 1, RESP_OKAY);
    wreg(ra(0, CH_SETV), 200);
    rreg(REG_DIAG, 0, RESP_OKAY);
    wreg(REG_STATUS, 32'hF);
    wreg(ra(0, CH_CFG), 32'h04);
    wreg(ra(0, CH_FAULTV), plc.enc(7770, 0));
    wreg(ra(1, CH_SETV), 300);
    wreg(ra(1, CH_FAULTV), 999);
    wreg(REG_CTRL, 1);
    wreg(ra(1, CH_SETV), 10);
    for (int p = 0; p < 4; p++) begin
      wreg(REG_CTRL, 0);
      wreg(ra(0, CH_SETV), 50 + p);
      wreg(REG_CTRL, (p << 4) | 1);
      wreg(ra(0, CH_SETV), 5);
    end
    wreg(REG_CTRL, 0);
    wreg(ra(0, CH_CFG), 32'h08);
    wreg(ra(0, CH_IDLEV), plc.enc(4440, 1));
    wreg(REG_CTRL, 2);
    wreg(ra(1, CH_SETV), 20);
    wreg(ra(0, CH_CFG), 32'h0C);
    wreg(REG_CTRL, 3);
    rreg(ra(0, CH_OUT), m_out[0] & 32'hFFFF, RESP_OKAY);
    wreg(REG_CTRL, 0);
    wreg(ra(0, CH_FAULTV), 32'h8005);
    wreg(ra(0, CH_IDLEV), 32'h8010);
    wreg(ra(0, CH_CFG), 32'h1C);
    wreg(REG_CTRL, 1);
    rreg(ra(0, CH_OUT), m_out[0] & 32'hFFFF, RESP_OKAY);
    wreg(REG_CTRL, 0);
    wreg(REG_CTRL, 2);
    wreg(REG_CTRL, 0);
    finish_test();
  end
endmodule
`default_nettype wire
